// ===== hw/rso_pkg.sv
// Package for the radio status and observation register bank.
// Notes on behaviour
// - Power field bits 2:1 picks -18, -12, -6 or 0 dBm; resets to 11.
// - Status byte shifts out on MISO while any command byte shifts in.
// - Receive-ready flag, bit 6, sets when a payload enters the queue.
// - Event flags clear only when the host writes one to their bit.
// - Sent flag, bit 5, sets on transmit, or on acknowledge if enabled.
// - Retry-limit flag, bit 4, sets at max retries and suspends traffic.
// - Bits 3:1 give head pipe; 110 unused, 111 empty; resets to 111.
// - Bit 0 is read-only and high while the transmit queue is full.
// - Lost packet count in observe bits 7:4 saturates at 15.
// - Any write to the channel register clears the lost packet count.
// - Retry count in bits 3:0 clears when a new packet starts.
// - Power detector is read-only bit 0; bits 7:1 read zero.
// - Pipe-0 address holds five bytes, least significant byte first.
// - Width code 01, 10, 11 means 3, 4, 5 bytes; low bytes used.
package rso_pkg;

  // Register offsets.
  localparam logic [4:0] RSO_REG_AW      = 5'h03;
  localparam logic [4:0] RSO_REG_CHANNEL = 5'h05;
  localparam logic [4:0] RSO_REG_RF      = 5'h06;
  localparam logic [4:0] RSO_REG_STATUS  = 5'h07;
  localparam logic [4:0] RSO_REG_OBSERVE = 5'h08;
  localparam logic [4:0] RSO_REG_POWER   = 5'h09;
  localparam logic [4:0] RSO_REG_P0ADDR  = 5'h0a;

  // Command byte layout: 000a_aaaa reads, 001a_aaaa writes a register.
  localparam logic [1:0] RSO_CMD_REGOP   = 2'h0;
  localparam int         RSO_CMD_WR_BIT  = 5;

  // Status field positions.
  localparam int RSO_ST_RXRDY = 6;
  localparam int RSO_ST_SENT  = 5;
  localparam int RSO_ST_RETRY = 4;

  // Reset values.
  localparam logic [1:0]  RSO_PWR_RST     = 2'h3;
  localparam logic [6:0]  RSO_CHANNEL_RST = 7'h02;
  localparam logic [1:0]  RSO_AW_RST      = 2'h3;
  localparam logic [2:0]  RSO_PIPE_EMPTY  = 3'h7;
  localparam logic [39:0] RSO_P0ADDR_RST  = 40'he7e7e7e7e7;
  localparam logic [3:0]  RSO_CNT_MAX     = 4'hf;
  localparam logic [2:0]  RSO_MAX_BYTES   = 3'h5;

  typedef enum logic [2:0] {
    RSO_IDLE = 3'b001,
    RSO_CMD  = 3'b010,
    RSO_DATA = 3'b100
  } rso_phase_t;

  // Events and levels from the packet engine, on the core clock.
  typedef struct packed {
    logic       rx_stored;
    logic [2:0] head_pipe;
    logic       tx_done;
    logic       ack_received;
    logic       auto_ack_on;
    logic       retry_limit_hit;
    logic       tx_queue_full;
    logic       packet_lost;
    logic       retransmit;
    logic       new_packet;
    logic       power_detect;
  } rso_radio_evt_t;

  // Settings handed to the radio.
  typedef struct packed {
    logic [1:0]  tx_power_level;
    logic [6:0]  channel_select;
    logic [1:0]  address_width_setting;
    logic [39:0] pipe0_receive_address;
    logic        comm_suspend;
  } rso_cfg_t;

  typedef struct packed {
    logic        sck_s1, sck_s2, sck_d;
    logic        csn_s1, csn_s2;
    logic        mosi_s1, mosi_s2;
    rso_phase_t  phase;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic        reg_cmd;
    logic        is_write;
    logic [4:0]  reg_addr;
    logic [2:0]  byte_idx;
    logic        miso;
    logic        miso_oe;
    rso_cfg_t    cfg;
    logic        rx_ready_flag;
    logic        tx_sent_flag;
    logic        retry_limit_flag;
    logic [2:0]  rx_pipe;
    logic        tx_full;
    logic [3:0]  lost_packet_count;
    logic [3:0]  retry_count;
    logic        received_power_flag;
  } rso_state_t;

  localparam rso_state_t RSO_STATE_RST = '{
    csn_s1: 1'b1, csn_s2: 1'b1, phase: RSO_IDLE, rx_pipe: RSO_PIPE_EMPTY,
    cfg: '{tx_power_level: RSO_PWR_RST, channel_select: RSO_CHANNEL_RST,
           address_width_setting: RSO_AW_RST,
           pipe0_receive_address: RSO_P0ADDR_RST, comm_suspend: 1'b0},
    default: '0};

endpackage : rso_pkg

// ===== hw/rso_regs.sv
// Serial register bank with status, observe counters and pipe-0 address.
`timescale 1ns/10ps
module rso_regs
  import rso_pkg::*;
(
  // Core clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Serial link from the host
  input  wire logic                    spi_sck,
  input  wire logic                    spi_csn_n,
  input  wire logic                    spi_mosi,
  output logic                         spi_miso,
  output logic                         spi_miso_oe,
  // Packet engine side
  input  rso_pkg::rso_radio_evt_t      radio_evt,
  output rso_pkg::rso_cfg_t            radio_cfg
);
  import rso_pkg::*;

  rso_state_t  state_r;
  rso_state_t  state_nxt;
  logic        sck_rise;
  logic        sck_fall;
  logic        byte_done;
  logic        wr_now;
  logic        chan_wr;
  logic        stat_wr;
  logic [7:0]  in_byte;
  logic [7:0]  clr_mask;
  logic [7:0]  rd_data;
  logic [2:0]  addr_bytes;
  logic [7:0]  st_now;

  // Width code 00 is illegal; it is handled like five bytes.
  function automatic logic [2:0] rso_width(input logic [1:0] aw);
    rso_width = (aw == 2'h0) ? RSO_MAX_BYTES : {1'b0, aw} + 3'h2;
  endfunction : rso_width

  function automatic logic [7:0] rso_status(input rso_state_t s);
    rso_status = {1'b0, s.rx_ready_flag, s.tx_sent_flag, s.retry_limit_flag,
                  s.rx_pipe, s.tx_full};
  endfunction : rso_status

  // Read mux; single-byte registers answer only on their first data byte.
  function automatic logic [7:0] rso_read(input rso_state_t s,
                                          input logic [2:0] nbytes);
    rso_read = 8'h00;
    if (s.reg_addr == RSO_REG_P0ADDR)
    begin
      if (s.byte_idx < nbytes)
      begin
        rso_read = s.cfg.pipe0_receive_address[{s.byte_idx, 3'h0} +: 8];
      end
    end
    else if (s.byte_idx == 3'h0)
    begin
      unique case (s.reg_addr)
        RSO_REG_AW:      rso_read = {6'h00, s.cfg.address_width_setting};
        RSO_REG_CHANNEL: rso_read = {1'b0, s.cfg.channel_select};
        RSO_REG_RF:      rso_read = {5'h00, s.cfg.tx_power_level, 1'b0};
        RSO_REG_STATUS:  rso_read = rso_status(s);
        RSO_REG_OBSERVE: rso_read = {s.lost_packet_count, s.retry_count};
        RSO_REG_POWER:   rso_read = {7'h00, s.received_power_flag};
        default:         rso_read = 8'h00;
      endcase
    end
  endfunction : rso_read

  always_comb
  begin
    state_nxt = state_r;
    // Pins are asynchronous to clk, so each passes two flops first.
    state_nxt.sck_s1  = spi_sck;
    state_nxt.sck_s2  = state_r.sck_s1;
    state_nxt.sck_d   = state_r.sck_s2;
    state_nxt.csn_s1  = spi_csn_n;
    state_nxt.csn_s2  = state_r.csn_s1;
    state_nxt.mosi_s1 = spi_mosi;
    state_nxt.mosi_s2 = state_r.mosi_s1;

    sck_rise   = state_r.sck_s2 & ~state_r.sck_d;
    sck_fall   = ~state_r.sck_s2 & state_r.sck_d;
    in_byte    = {state_r.rx_sh[6:0], state_r.mosi_s2};
    byte_done  = sck_rise & (state_r.bit_cnt == 3'h7) & ~state_r.csn_s2 &
                 (state_r.phase != RSO_IDLE);
    wr_now     = byte_done & (state_r.phase == RSO_DATA) &
                 state_r.reg_cmd & state_r.is_write;
    chan_wr    = wr_now & (state_r.reg_addr == RSO_REG_CHANNEL) &
                 (state_r.byte_idx == 3'h0);
    stat_wr    = wr_now & (state_r.reg_addr == RSO_REG_STATUS) &
                 (state_r.byte_idx == 3'h0);
    clr_mask   = stat_wr ? in_byte : 8'h00;
    addr_bytes = rso_width(state_r.cfg.address_width_setting);
    st_now     = rso_status(state_r);
    rd_data    = (state_r.reg_cmd & ~state_r.is_write) ?
                 rso_read(state_r, addr_bytes) : 8'h00;

    state_nxt.tx_full = radio_evt.tx_queue_full;
    state_nxt.rx_pipe = radio_evt.head_pipe;
    state_nxt.received_power_flag = radio_evt.power_detect;

    // write-one clear
    // A new event in the clearing cycle wins, so no event is lost.
    // receive-ready set
    state_nxt.rx_ready_flag = (state_r.rx_ready_flag &
                               ~clr_mask[RSO_ST_RXRDY]) | radio_evt.rx_stored;
    state_nxt.tx_sent_flag = (state_r.tx_sent_flag & ~clr_mask[RSO_ST_SENT]) |
                             (radio_evt.auto_ack_on ? radio_evt.ack_received
                                                    : radio_evt.tx_done);
    state_nxt.retry_limit_flag = (state_r.retry_limit_flag &
                                  ~clr_mask[RSO_ST_RETRY]) |
                                 radio_evt.retry_limit_hit;
    state_nxt.cfg.comm_suspend = state_nxt.retry_limit_flag;

    // channel write clears
    // The host clear wins over a loss counted in the same cycle.
    if (chan_wr)
    begin
      state_nxt.lost_packet_count = 4'h0;
    end
    else if (radio_evt.packet_lost &&
             state_r.lost_packet_count != RSO_CNT_MAX)
    begin
      state_nxt.lost_packet_count = state_r.lost_packet_count + 4'h1;
    end

    if (radio_evt.new_packet)
    begin
      state_nxt.retry_count = 4'h0;
    end
    else if (radio_evt.retransmit && state_r.retry_count != RSO_CNT_MAX)
    begin
      state_nxt.retry_count = state_r.retry_count + 4'h1;
    end

    if (wr_now)
    begin
      if (state_r.reg_addr == RSO_REG_P0ADDR)
      begin
        if (state_r.byte_idx < addr_bytes)
        begin
          state_nxt.cfg.pipe0_receive_address[{state_r.byte_idx, 3'h0} +: 8]
            = in_byte;
        end
      end
      else if (state_r.byte_idx == 3'h0)
      begin
        if (state_r.reg_addr == RSO_REG_CHANNEL)
        begin
          state_nxt.cfg.channel_select = in_byte[6:0];
        end
        if (state_r.reg_addr == RSO_REG_AW)
        begin
          state_nxt.cfg.address_width_setting = in_byte[1:0];
        end
        if (state_r.reg_addr == RSO_REG_RF)
        begin
          state_nxt.cfg.tx_power_level = in_byte[2:1];
        end
      end
    end

    unique case (state_r.phase)
      RSO_IDLE:
      begin
        if (!state_r.csn_s2)
        begin
          state_nxt.phase   = RSO_CMD;
          state_nxt.bit_cnt = 3'h0;
          state_nxt.miso    = st_now[7];
          state_nxt.tx_sh   = {st_now[6:0], 1'b0};
          state_nxt.miso_oe = 1'b1;
        end
      end
      RSO_CMD, RSO_DATA:
      begin
        if (state_r.csn_s2)
        begin
          state_nxt.phase   = RSO_IDLE;
          state_nxt.miso    = 1'b0;
          state_nxt.miso_oe = 1'b0;
        end
        else
        begin
          if (sck_rise)
          begin
            state_nxt.rx_sh   = in_byte;
            state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
          end
          if (byte_done && state_r.phase == RSO_CMD)
          begin
            state_nxt.phase    = RSO_DATA;
            state_nxt.reg_cmd  = (in_byte[7:6] == RSO_CMD_REGOP);
            state_nxt.is_write = in_byte[RSO_CMD_WR_BIT];
            state_nxt.reg_addr = in_byte[4:0];
            state_nxt.byte_idx = 3'h0;
          end
          else if (byte_done && state_r.byte_idx != 3'h7)
          begin
            state_nxt.byte_idx = state_r.byte_idx + 3'h1;
          end
          // Mode 0: the next bit is put out on the falling edge.
          if (sck_fall)
          begin
            if (state_r.bit_cnt == 3'h0)
            begin
              state_nxt.miso  = rd_data[7];
              state_nxt.tx_sh = {rd_data[6:0], 1'b0};
            end
            else
            begin
              state_nxt.miso  = state_r.tx_sh[7];
              state_nxt.tx_sh = {state_r.tx_sh[6:0], 1'b0};
            end
          end
        end
      end
      default:
      begin
        state_nxt.phase = RSO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= RSO_STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign spi_miso    = state_r.miso;
  assign spi_miso_oe = state_r.miso_oe;
  assign radio_cfg   = state_r.cfg;

  default clocking rso_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // The disable clause masks every reset cycle, so look just after release.
  a_pwr_reset: assert property ($fell(sys_rst) |->
    radio_cfg.tx_power_level == RSO_PWR_RST)
    else $error("Power field did not reset to 11.");
  a_status_lead: assert property (
    (state_r.phase == RSO_IDLE && !state_r.csn_s2) |=>
    spi_miso_oe && !spi_miso &&
    state_r.tx_sh[7] == $past(state_r.rx_ready_flag))
    else $error("Status byte not loaded at frame start.");
  a_rx_ready_set: assert property (radio_evt.rx_stored |=>
    state_r.rx_ready_flag)
    else $error("Receive-ready flag missed a stored payload.");
  a_flag_hold: assert property (
    (state_r.tx_sent_flag && !stat_wr) |=> state_r.tx_sent_flag)
    else $error("Sent flag dropped without a host clear.");
  a_flag_clear: assert property (
    (stat_wr && in_byte[RSO_ST_RXRDY] && !radio_evt.rx_stored) |=>
    !state_r.rx_ready_flag)
    else $error("Write of one did not clear receive-ready.");
  a_sent_ack: assert property (
    (radio_evt.auto_ack_on && radio_evt.tx_done &&
     !radio_evt.ack_received && !state_r.tx_sent_flag) |=>
    !state_r.tx_sent_flag)
    else $error("Sent flag set without acknowledge.");
  a_retry_suspend: assert property (
    radio_evt.retry_limit_hit |=> state_r.retry_limit_flag ##0
    radio_cfg.comm_suspend)
    else $error("Retry limit did not suspend traffic.");
  a_pipe_follow: assert property (
    1'b1 |=> state_r.rx_pipe == $past(radio_evt.head_pipe))
    else $error("Pipe field does not follow queue head.");
  a_full_follow: assert property (
    1'b1 |=> state_r.tx_full == $past(radio_evt.tx_queue_full))
    else $error("Full bit does not follow the queue.");
  a_lost_sat: assert property (
    (state_r.lost_packet_count == RSO_CNT_MAX && !chan_wr) |=>
    state_r.lost_packet_count == RSO_CNT_MAX)
    else $error("Lost count left saturation.");
  a_lost_clear: assert property (chan_wr |=>
    state_r.lost_packet_count == 4'h0)
    else $error("Channel write did not clear lost count.");
  a_retry_new: assert property (radio_evt.new_packet |=>
    state_r.retry_count == 4'h0)
    else $error("Retry count not cleared on new packet.");

  c_read_frame: cover property (byte_done && state_r.phase == RSO_DATA &&
                                !state_r.is_write);
  c_status_clear: cover property (stat_wr && clr_mask != 8'h00);
  c_addr_write: cover property (wr_now &&
                                state_r.reg_addr == RSO_REG_P0ADDR &&
                                state_r.byte_idx == 3'h4);
  c_lost_full: cover property (state_r.lost_packet_count == RSO_CNT_MAX);

endmodule : rso_regs

// ===== verif/rso_host.sv
// Host model that masters the serial register link.
`timescale 1ns/10ps
module rso_host
(
  // Core clock that paces the link
  input  wire logic clk,
  // Serial link
  output logic      spi_sck,
  output logic      spi_csn_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sck   = 1'b0;
    spi_csn_n = 1'b1;
    spi_mosi  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // Four core clocks per half period give a 200 ns link clock.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      wait_clk(4);
      rx[i]   = spi_miso;
      spi_sck = 1'b1;
      wait_clk(4);
      spi_sck = 1'b0;
    end
  endtask : xfer

  task automatic frame(input logic [7:0] cmd, input int n,
                       input logic [39:0] wd, output logic [7:0] st,
                       output logic [39:0] rd);
    logic [7:0] b;
    rd = '0;
    wait_clk(1);
    spi_csn_n = 1'b0;
    wait_clk(6);
    xfer(cmd, st);
    for (int k = 0; k < n; k++)
    begin
      xfer(wd[8*k +: 8], b);
      rd[8*k +: 8] = b;
    end
    wait_clk(4);
    spi_csn_n = 1'b1;
    // The released data line shows the inverse of its last bit.
    spi_mosi = ~spi_mosi;
    wait_clk(6);
  endtask : frame
endmodule : rso_host

// ===== verif/testbench.sv
// Self-checking bench for the status and observation register bank.
`timescale 1ns/10ps
module testbench;
  import rso_pkg::*;
  localparam logic [12:0] RX_M = 13'h1000, SENT_M = 13'h0100;
  localparam logic [12:0] ACK_M = 13'h0080, RTY_M = 13'h0020;
  localparam logic [12:0] LOST_M = 13'h0008, RETX_M = 13'h0004;
  localparam logic [12:0] NEWP_M = 13'h0002;
  logic           clk;
  logic           sys_rst;
  logic           spi_sck;
  logic           spi_csn_n;
  logic           spi_mosi;
  logic           spi_miso;
  logic           spi_miso_oe;
  rso_radio_evt_t evt;
  rso_cfg_t       cfg;
  int             bad_count = 0;
  int             cmp_count = 0;
  int             cycles = 0;
  logic [7:0]     st;
  logic [39:0]    v;

  rso_regs rso_regs_i (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
    .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .radio_evt(evt), .radio_cfg(cfg));
  rso_host rso_host_i (.clk(clk), .spi_sck(spi_sck), .spi_csn_n(spi_csn_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The tests need about 6600 cycles.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input int n);
    rso_host_i.frame({3'h0, a}, n, 40'h0, st, v);
  endtask : rd

  task automatic wr(input logic [4:0] a, input int n, input logic [39:0] d);
    rso_host_i.frame({3'h1, a}, n, d, st, v);
  endtask : wr

  task automatic pulse(input logic [12:0] m, input int n);
    repeat (n)
    begin
      @(negedge clk);
      evt = evt | m;
      @(negedge clk);
      evt = evt & ~m;
    end
  endtask : pulse

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  initial
  begin
    sys_rst = 1'b1;
    evt = '0;
    evt.head_pipe = 3'h7;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(RSO_REG_STATUS, 1);
    check("status shift", st, 40'h0e);
    check("status", v, 40'h0e);
    check("miso idle", {spi_miso_oe, spi_miso}, 40'h0);
    rd(RSO_REG_OBSERVE, 1);
    check("observe", v, 40'h00);
    rd(RSO_REG_POWER, 1);
    check("detector", v, 40'h00);
    rd(RSO_REG_P0ADDR, 5);
    check("address", v, 40'he7e7e7e7e7);
    rd(RSO_REG_RF, 1);
    check("power reg", v, 40'h06);
    done("reset");
    for (int p = 0; p < 4; p++)
    begin
      wr(RSO_REG_RF, 1, 40'(p << 1));
      rd(RSO_REG_RF, 1);
      check("power field", v, 40'(p << 1));
      check("power out", cfg.tx_power_level, 40'(p));
    end
    done("power");
    pulse(RX_M | SENT_M | RTY_M, 1);
    rd(RSO_REG_STATUS, 0);
    check("flags", st, 40'h7e);
    check("suspend", cfg.comm_suspend, 40'h1);
    wr(RSO_REG_STATUS, 1, 40'h0f);
    rd(RSO_REG_STATUS, 0);
    check("zero write", st, 40'h7e);
    wr(RSO_REG_STATUS, 1, 40'h20);
    rd(RSO_REG_STATUS, 0);
    check("sent clr", st, 40'h5e);
    wr(RSO_REG_STATUS, 1, 40'h50);
    rd(RSO_REG_STATUS, 0);
    check("all clr", st, 40'h0e);
    check("resume", cfg.comm_suspend, 40'h0);
    evt.auto_ack_on = 1'b1;
    pulse(SENT_M, 1);
    rd(RSO_REG_STATUS, 0);
    check("no ack", st, 40'h0e);
    pulse(ACK_M, 1);
    rd(RSO_REG_STATUS, 0);
    check("acked", st, 40'h2e);
    wr(RSO_REG_STATUS, 1, 40'h20);
    done("flags");
    evt.tx_queue_full = 1'b1;
    for (int p = 0; p < 8; p++)
    begin
      evt.head_pipe = 3'(p);
      rd(RSO_REG_STATUS, 0);
      check("pipe full", st, 40'(2 * p + 1));
    end
    evt.tx_queue_full = 1'b0;
    done("pipe");
    pulse(LOST_M, 17);
    pulse(RETX_M, 3);
    wr(RSO_REG_OBSERVE, 1, 40'h00);
    rd(RSO_REG_OBSERVE, 1);
    check("counts", v, 40'hf3);
    pulse(NEWP_M, 1);
    rd(RSO_REG_OBSERVE, 1);
    check("new pkt", v, 40'hf0);
    wr(RSO_REG_CHANNEL, 1, 40'h10);
    rd(RSO_REG_OBSERVE, 1);
    check("chan clr", v, 40'h00);
    check("channel", cfg.channel_select, 40'h10);
    evt.power_detect = 1'b1;
    rd(RSO_REG_POWER, 1);
    check("detector on", v, 40'h01);
    done("observe");
    wr(RSO_REG_AW, 1, 40'h01);
    check("width", cfg.address_width_setting, 40'h1);
    wr(RSO_REG_P0ADDR, 3, 40'h332211);
    check("addr 3", cfg.pipe0_receive_address, 40'he7e7332211);
    wr(RSO_REG_AW, 1, 40'h02);
    wr(RSO_REG_P0ADDR, 4, 40'h5544aabbcc);
    check("addr 4", cfg.pipe0_receive_address, 40'he744aabbcc);
    wr(RSO_REG_AW, 1, 40'h03);
    wr(RSO_REG_P0ADDR, 5, 40'h0102030405);
    rd(RSO_REG_P0ADDR, 5);
    check("addr 5", v, 40'h0102030405);
    done("address");
    report_and_stop();
  end
endmodule : testbench
